// ### core/tes_status_bank.v
// tape extended status register bank with termination class reporting
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "tes_map.vh"
module tes_status_bank (
  input wire clk_sys_i, // system clock 100 MHz
  input wire arst_n_i, // async reset, active low
  input wire [3:0] reg_addr_i, // register index
  input wire [15:0] reg_wdata_i, // write data
  input wire reg_wr_i, // write strobe
  input wire reg_rd_i, // read strobe
  output reg [15:0] reg_rdata_o, // read data, cycle after strobe
  input wire cmd_start_i, // controller accepts a new command
  input wire [2:0] cmd_code_i, // command being started
  input wire cmd_done_i, // command completed pulse
  input wire [15:0] residual_i, // residual count at completion
  input wire tape_mark_i, // tape mark detected pulse
  input wire short_len_i, // read record shorter than byte count
  input wire long_len_i, // read record longer than byte count
  input wire count_left_i, // position count not exhausted at stop
  input wire bot_stop_i, // stopped on load point pulse
  input wire recov_err_i, // recoverable error pulse
  input wire fatal_err_i, // fatal controller error pulse
  input wire [15:0] bus_addr_i, // current bus address low word
  input wire [15:0] extended_status_1_i, // extended status word 1 from controller
  input wire [15:0] extended_status_2_i, // extended status word 2 from controller
  input wire [15:0] extended_status_3_i, // extended status word 3 from controller
  input wire ring_absent_pin_i, // write ring missing, pin
  input wire protect_sw_pin_i, // write protect switch, pin
  output reg [15:0] cmd_ptr_o, // command pointer written by host
  output reg cmd_ptr_wr_o, // pulse on command pointer write
  output reg irq_o // level interrupt
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_BUSY = 4'b0010;
  localparam ST_LEFT_BOT = 4'b0100;
  localparam ST_AFTER_TMK = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////
  wire [1:0] pins_sync;
  wire ring_absent;
  wire write_protect_switch;
  tes_sync2 #(.WIDTH(2)) u_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i({protect_sw_pin_i, ring_absent_pin_i}),
    .sync_o(pins_sync)
  );
  assign ring_absent = pins_sync[0];
  assign write_protect_switch = pins_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  reg [3:0] state;
  reg [3:0] next_state;
  reg [2:0] cur_cmd;
  reg let_enable;
  reg special_condition;
  reg [2:0] termination_class;
  reg [15:0] residual_count;
  reg tape_mark_seen;
  reg short_record;
  reg logical_end;
  reg long_record;
  reg write_lock_error;
  reg ev_reject;
  reg ev_trip;
  reg ev_recov;
  reg ev_fatal;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  wire [2:0] class_now;
  wire is_read = (cur_cmd == `TES_CMD_READ);
  wire is_space = (cur_cmd == `TES_CMD_SPACE);
  wire is_skip = (cur_cmd == `TES_CMD_SKIP_TMK);
  wire is_write = (cur_cmd == `TES_CMD_WRITE);
  wire busy = (state != ST_IDLE);
  wire alert = tape_mark_seen | short_record | logical_end | long_record;

  tes_term_class u_class (
    .fatal_i(ev_fatal),
    .protect_trip_i(ev_trip),
    .recov_i(ev_recov),
    .reject_i(ev_reject),
    .alert_i(alert),
    .class_o(class_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // skip tape marks tracking for logical end detection
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_start_i) begin
          next_state = (cmd_code_i == `TES_CMD_SKIP_TMK) ? ST_LEFT_BOT : ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (cmd_done_i) begin
          next_state = ST_IDLE;
        end
      end
      ST_LEFT_BOT: begin
        if (cmd_done_i) begin
          next_state = ST_IDLE;
        end else if (tape_mark_i) begin
          next_state = ST_AFTER_TMK;
        end
      end
      ST_AFTER_TMK: begin
        if (cmd_done_i) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // tracks whether skip started from load point before first record
  reg from_bot;
  reg rec_seen;
  wire let_hit = is_skip && let_enable && tape_mark_i &&
    ((state == ST_AFTER_TMK && !rec_seen) || (from_bot && state == ST_LEFT_BOT));

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      cur_cmd <= `TES_CMD_OTHER;
      from_bot <= 1'b0;
      rec_seen <= 1'b0;
    end else begin
      state <= next_state;
      if (cmd_start_i && !busy) begin
        cur_cmd <= cmd_code_i;
        from_bot <= bot_stop_i;
        rec_seen <= 1'b0;
      end else if (tape_mark_i) begin
        from_bot <= 1'b0;
        rec_seen <= 1'b0;
      end else if (short_len_i | long_len_i) begin
        from_bot <= 1'b0;
        rec_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire new_cmd = cmd_start_i && !busy;
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tape_mark_seen <= 1'b0;
      short_record <= 1'b0;
      logical_end <= 1'b0;
      long_record <= 1'b0;
      write_lock_error <= 1'b0;
      ev_reject <= 1'b0;
      ev_trip <= 1'b0;
      ev_recov <= 1'b0;
      ev_fatal <= 1'b0;
      residual_count <= `TES_RESET_WORD;
      special_condition <= 1'b0;
      termination_class <= `TES_TC_NORMAL;
    end else if (new_cmd) begin
      tape_mark_seen <= 1'b0;
      short_record <= 1'b0;
      logical_end <= 1'b0;
      long_record <= 1'b0;
      ev_trip <= 1'b0;
      ev_recov <= 1'b0;
      ev_fatal <= 1'b0;
      special_condition <= 1'b0;
      termination_class <= `TES_TC_NORMAL;
      write_lock_error <= (cmd_code_i == `TES_CMD_WRITE) && ring_absent;
      ev_reject <= (cmd_code_i == `TES_CMD_WRITE) && ring_absent;
    end else if (busy) begin
      // mark seen in read space skip
      if (tape_mark_i && (is_read || is_space || is_skip)) begin
        tape_mark_seen <= 1'b1;
      end
      if (cmd_done_i && (cur_cmd == `TES_CMD_WRITE_TMK ||
                         cur_cmd == `TES_CMD_WRITE_TMK_RETRY)) begin
        tape_mark_seen <= 1'b1;
      end
      if (short_len_i && is_read) begin
        short_record <= 1'b1;
      end
      if (is_space && count_left_i && (tape_mark_i || bot_stop_i)) begin
        short_record <= 1'b1;
      end
      if (is_skip && count_left_i && (bot_stop_i || let_hit)) begin
        short_record <= 1'b1;
      end
      if (let_hit) begin
        logical_end <= 1'b1;
      end
      if (long_len_i && is_read) begin
        long_record <= 1'b1;
      end
      if (is_write && write_protect_switch) begin
        write_lock_error <= 1'b1;
        ev_trip <= 1'b1;
      end
      if (recov_err_i) begin
        ev_recov <= 1'b1;
      end
      if (fatal_err_i) begin
        ev_fatal <= 1'b1;
      end
      // residual only for read space skip
      if (cmd_done_i && (is_read || is_space || is_skip)) begin
        residual_count <= residual_i;
      end
      if (cmd_done_i) begin
        termination_class <= class_now;
        special_condition <= (class_now != `TES_TC_NORMAL);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire [15:0] extended_status_0_word = {tape_mark_seen, short_record, logical_end, long_record,
    write_lock_error, 11'h000};
  wire [15:0] subsys_word = {special_condition, 7'h00, !busy, 3'h0,
    termination_class, 1'b0};
  wire [2:0] irq_events = {cmd_ptr_wr_o, cmd_done_i & busy & (class_now != `TES_TC_NORMAL),
    cmd_done_i & busy};

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      let_enable <= 1'b0;
      irq_mask <= 3'h0;
      cmd_ptr_o <= `TES_RESET_WORD;
      cmd_ptr_wr_o <= 1'b0;
    end else begin
      cmd_ptr_wr_o <= reg_wr_i && (reg_addr_i == `TES_OFF_CMD_PTR);
      if (reg_wr_i) begin
        if (reg_addr_i == `TES_OFF_CMD_PTR) begin
          cmd_ptr_o <= reg_wdata_i;
        end else if (reg_addr_i == `TES_OFF_CHAR) begin
          let_enable <= reg_wdata_i[0];
        end else if (reg_addr_i == `TES_OFF_IRQ_MASK) begin
          irq_mask <= reg_wdata_i[2:0];
        end
      end
    end
  end

  // sticky status, event set wins over read clear
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      if (reg_rd_i && reg_addr_i == `TES_OFF_IRQ_STAT) begin
        irq_status <= irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      irq_o <= |(irq_status & irq_mask);
    end
  end

  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `TES_OFF_BUS_ADDR) begin
        reg_rdata_o <= bus_addr_i;
      end else if (reg_addr_i == `TES_OFF_SUBSYS) begin
        reg_rdata_o <= subsys_word;
      end else if (reg_addr_i == `TES_OFF_RESIDUAL) begin
        reg_rdata_o <= residual_count;
      end else if (reg_addr_i == `TES_OFF_EXTENDED_STATUS_0) begin
        reg_rdata_o <= extended_status_0_word;
      end else if (reg_addr_i == `TES_OFF_EXTENDED_STATUS_1) begin
        reg_rdata_o <= extended_status_1_i;
      end else if (reg_addr_i == `TES_OFF_EXTENDED_STATUS_2) begin
        reg_rdata_o <= extended_status_2_i;
      end else if (reg_addr_i == `TES_OFF_EXTENDED_STATUS_3) begin
        reg_rdata_o <= extended_status_3_i;
      end else if (reg_addr_i == `TES_OFF_CHAR) begin
        reg_rdata_o <= {15'h0000, let_enable};
      end else if (reg_addr_i == `TES_OFF_IRQ_STAT) begin
        reg_rdata_o <= {13'h0000, irq_status};
      end else if (reg_addr_i == `TES_OFF_IRQ_MASK) begin
        reg_rdata_o <= {13'h0000, irq_mask};
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
endmodule // tes_status_bank

// ### common/tes_map.vh
// register offsets, field positions, codes and reset values of the tape status bank
`ifndef TES_MAP_VH
`define TES_MAP_VH
`define TES_OFF_BUS_ADDR 4'h0
`define TES_OFF_CMD_PTR 4'h1
`define TES_OFF_SUBSYS 4'h2
`define TES_OFF_RESIDUAL 4'h3
`define TES_OFF_EXTENDED_STATUS_0 4'h4
`define TES_OFF_EXTENDED_STATUS_1 4'h5
`define TES_OFF_EXTENDED_STATUS_2 4'h6
`define TES_OFF_EXTENDED_STATUS_3 4'h7
`define TES_OFF_CHAR 4'h8
`define TES_OFF_IRQ_STAT 4'h9
`define TES_OFF_IRQ_MASK 4'hA
`define TES_BIT_TMK 15
`define TES_BIT_SHORT 14
`define TES_BIT_LET 13
`define TES_BIT_LONG 12
`define TES_BIT_WLE 11
`define TES_BIT_SC 15
`define TES_BIT_READY 7
`define TES_TC_LSB 1
`define TES_TC_NORMAL 3'h0
`define TES_TC_ATTN 3'h1
`define TES_TC_ALERT 3'h2
`define TES_TC_REJECT 3'h3
`define TES_TC_RECOV 3'h4
`define TES_TC_RECOV_NOMOVE 3'h5
`define TES_TC_UNRECOV 3'h6
`define TES_TC_FATAL 3'h7
`define TES_CMD_READ 3'h0
`define TES_CMD_SPACE 3'h1
`define TES_CMD_SKIP_TMK 3'h2
`define TES_CMD_WRITE 3'h3
`define TES_CMD_WRITE_TMK 3'h4
`define TES_CMD_WRITE_TMK_RETRY 3'h5
`define TES_CMD_OTHER 3'h6
`define TES_RESET_WORD 16'h0000
`define TES_IRQ_DONE 0
`define TES_IRQ_SC 1
`define TES_IRQ_CMDPTR 2
`endif

// ### core/tes_term_class.v
// termination class encoder choosing the most severe pending class
`timescale 1ns/1ps
`include "tes_map.vh"
module tes_term_class (
  input wire fatal_i, // controller fatal error
  input wire protect_trip_i, // write protect switch during write
  input wire recov_i, // recoverable error, tape one record on
  input wire reject_i, // function reject
  input wire alert_i, // tape status alert
  output reg [2:0] class_o // encoded termination class
);
  always @* begin
    class_o = `TES_TC_NORMAL;
    if (fatal_i) begin
      class_o = `TES_TC_FATAL;
    end else if (protect_trip_i) begin
      class_o = `TES_TC_UNRECOV;
    end else if (recov_i) begin
      class_o = `TES_TC_RECOV;
    end else if (reject_i) begin
      class_o = `TES_TC_REJECT;
    end else if (alert_i) begin
      class_o = `TES_TC_ALERT;
    end
  end
endmodule // tes_term_class

// ### core/tes_sync2.v
// two flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module tes_sync2 #(
  parameter WIDTH = 2
) (
  input wire clk_sys_i, // system clock
  input wire arst_n_i, // async reset, active low
  input wire [WIDTH-1:0] async_i, // pin levels
  output reg [WIDTH-1:0] sync_o // synchronised levels
);
  reg [WIDTH-1:0] stage1;
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage1 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // tes_sync2

// ### tb/tes_status_bank_monitor.sv
// checker for the register port and command pointer of the status bank
`timescale 1ns/1ps
module tes_status_bank_monitor (
  input wire clk_sys_i, // system clock
  input wire arst_n_i, // async reset, active low
  input wire [3:0] reg_addr_i, // register index
  input wire [15:0] reg_wdata_i, // write data
  input wire reg_wr_i, // write strobe
  input wire reg_rd_i, // read strobe
  input wire [15:0] reg_rdata_o, // read data
  input wire [15:0] bus_addr_i, // bus address word
  input wire [15:0] extended_status_1_i, // status word 1
  input wire [15:0] cmd_ptr_o, // command pointer
  input wire cmd_ptr_wr_o // pointer write pulse
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read slot");
  a_bus_addr_rd: assert property (reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o == $past(bus_addr_i))
    else $error("bus address read wrong");
  a_extended_status_1_read: assert property (reg_rd_i && reg_addr_i == 4'h5 |=> reg_rdata_o == $past(extended_status_1_i))
    else $error("status word 1 read wrong");
  a_extended_status_0_low_zero: assert property (reg_rd_i && reg_addr_i == 4'h4 |=> reg_rdata_o[10:0] == 11'h000)
    else $error("status word 0 low bits not zero");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 4'hA |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_ptr_load: assert property (reg_wr_i && reg_addr_i == 4'h1 |=>
    cmd_ptr_wr_o && cmd_ptr_o == $past(reg_wdata_i)) else $error("command pointer not loaded");
  a_ptr_cause: assert property (cmd_ptr_wr_o |-> $past(reg_wr_i) && $past(reg_addr_i) == 4'h1)
    else $error("pointer pulse without write");
  a_ptr_hold: assert property (!(reg_wr_i && reg_addr_i == 4'h1) |=> $stable(cmd_ptr_o))
    else $error("command pointer changed without write");
endmodule // tes_status_bank_monitor
bind tes_status_bank tes_status_bank_monitor u_mon (.clk_sys_i, .arst_n_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_addr_i, .extended_status_1_i, .cmd_ptr_o,
  .cmd_ptr_wr_o);

// ### tb/tes_ctl_model.sv
// controller model that runs one command with its events into the bank
`timescale 1ns/1ps
module tes_ctl_model (
  input wire clk_sys_i, // system clock
  output logic cmd_start_i, // command accepted
  output logic [2:0] cmd_code_i, // command code
  output logic cmd_done_i, // completion pulse
  output logic [15:0] residual_i, // residual count
  output logic tape_mark_i, // tape mark pulse
  output logic short_len_i, // short record pulse
  output logic long_len_i, // long record pulse
  output logic count_left_i, // count not exhausted
  output logic recov_err_i, // recoverable error pulse
  output logic fatal_err_i, // fatal error pulse
  output logic bot_stop_i // load point stop pulse
);
  initial begin
    {cmd_start_i, cmd_code_i, cmd_done_i, residual_i, tape_mark_i} = '0;
    {short_len_i, long_len_i, count_left_i, recov_err_i, fatal_err_i, bot_stop_i} = '0;
  end
  // ev[4] is a load point stop, shown with the start and again with the events
  task run(input logic [2:0] code, input int tm, input logic [4:0] ev, input logic cl,
    input logic [15:0] res, input int gap);
    @(posedge clk_sys_i);
    cmd_start_i <= 1'b1;
    cmd_code_i <= code;
    count_left_i <= cl;
    bot_stop_i <= ev[4];
    @(posedge clk_sys_i);
    cmd_start_i <= 1'b0;
    if (tm > 0) begin
      bot_stop_i <= 1'b0;
    end
    // marks back to back, no record between
    repeat (tm) begin
      tape_mark_i <= 1'b1;
      @(posedge clk_sys_i);
    end
    tape_mark_i <= 1'b0;
    {bot_stop_i, fatal_err_i, recov_err_i, long_len_i, short_len_i} <= ev;
    @(posedge clk_sys_i);
    {bot_stop_i, fatal_err_i, recov_err_i, long_len_i, short_len_i} <= 5'h00;
    repeat (gap) @(posedge clk_sys_i);
    cmd_done_i <= 1'b1;
    residual_i <= res;
    @(posedge clk_sys_i);
    cmd_done_i <= 1'b0;
    // residual no longer held after the done pulse
    residual_i <= ~res;
    @(posedge clk_sys_i);
  endtask
endmodule // tes_ctl_model

// ### tb/tes_status_bank_tb_top.sv
// self-checking bench for the tape status bank
`timescale 1ns/1ps
`include "tes_map.vh"
module tes_status_bank_tb_top;
  logic clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i, cmd_start_i, cmd_done_i, tape_mark_i;
  logic short_len_i, long_len_i, count_left_i, recov_err_i, fatal_err_i, cmd_ptr_wr_o;
  logic ring_absent_pin_i, protect_sw_pin_i, irq_o, bot_stop_i;
  logic [2:0] cmd_code_i;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, residual_i, cmd_ptr_o, d;
  logic [15:0] bus_addr_i = 16'hA5C3;
  logic [15:0] extended_status_1_i = 16'h3C5A;
  int n_fail = 0;
  int comparisons = 0;
  tes_status_bank u_dut (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .cmd_start_i, .cmd_code_i, .cmd_done_i, .residual_i,
    .tape_mark_i, .short_len_i, .long_len_i, .count_left_i, .bot_stop_i, .recov_err_i,
    .fatal_err_i, .bus_addr_i, .extended_status_1_i, .extended_status_2_i(16'h0F0F), .extended_status_3_i(16'hF0F0),
    .ring_absent_pin_i, .protect_sw_pin_i, .cmd_ptr_o, .cmd_ptr_wr_o, .irq_o);
  tes_ctl_model u_ctl (.clk_sys_i, .cmd_start_i, .cmd_code_i, .cmd_done_i, .residual_i,
    .tape_mark_i, .short_len_i, .long_len_i, .count_left_i, .recov_err_i, .fatal_err_i,
    .bot_stop_i);
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // one command, then status word 0, class and, for read, space and skip, residual; cls below 0 skips the class
  task sc(input logic [2:0] c, input int tm, input logic [4:0] ev, input logic cl,
    input logic [15:0] r, input int gap, input logic [15:0] x0, input int cls, input logic p);
    repeat (3) @(posedge clk_sys_i);
    fork
      u_ctl.run(c, tm, ev, cl, r, gap);
      begin
        repeat (3) @(posedge clk_sys_i);
        protect_sw_pin_i <= p;
      end
    join
    protect_sw_pin_i <= 1'b0;
    rd(`TES_OFF_EXTENDED_STATUS_0);
    chk("extended_status_0", x0, d);
    if (cls >= 0) begin
      rd(`TES_OFF_SUBSYS);
      chk("class", {8'h80, 4'h8, cls[2:0], 1'b0}, d & 16'h808E);
    end
    if (c <= `TES_CMD_SKIP_TMK) begin
      rd(`TES_OFF_RESIDUAL);
      chk("residual", r, d);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_fail++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n_i, reg_wr_i, reg_rd_i, ring_absent_pin_i, protect_sw_pin_i} = '0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd(`TES_OFF_EXTENDED_STATUS_0);
    chk("extended_status_0 reset", `TES_RESET_WORD, d);
    rd(`TES_OFF_SUBSYS);
    chk("status reset", 16'h0080, d & 16'h808E);
    rd(`TES_OFF_BUS_ADDR);
    chk("bus addr", 16'hA5C3, d);
    rd(`TES_OFF_EXTENDED_STATUS_1);
    chk("extended_status_1", 16'h3C5A, d);
    rd(`TES_OFF_EXTENDED_STATUS_2);
    chk("extended_status_2", 16'h0F0F, d);
    rd(`TES_OFF_EXTENDED_STATUS_3);
    chk("extended_status_3", 16'hF0F0, d);
    sc(`TES_CMD_READ, 0, 5'h01, 0, 16'h0005, 0, 16'h4000, `TES_TC_ALERT, 0);
    sc(`TES_CMD_READ, 0, 5'h02, 0, 16'h0007, 0, 16'h1000, `TES_TC_ALERT, 0);
    sc(`TES_CMD_READ, 1, 5'h00, 0, 16'h0009, 0, 16'h8000, -1, 0);
    sc(`TES_CMD_SPACE, 1, 5'h00, 1, 16'h0003, 0, 16'hC000, `TES_TC_ALERT, 0);
    sc(`TES_CMD_SPACE, 0, 5'h10, 1, 16'h0004, 0, 16'h4000, `TES_TC_ALERT, 0);
    sc(`TES_CMD_SKIP_TMK, 2, 5'h00, 0, 16'h0000, 0, 16'h8000, -1, 0);
    wr(`TES_OFF_CHAR, 16'h0001);
    sc(`TES_CMD_SKIP_TMK, 2, 5'h00, 1, 16'h0002, 0, 16'hE000, `TES_TC_ALERT, 0);
    sc(`TES_CMD_SKIP_TMK, 1, 5'h10, 0, 16'h0001, 0, 16'hA000, `TES_TC_ALERT, 0);
    sc(`TES_CMD_SKIP_TMK, 0, 5'h10, 1, 16'h0006, 0, 16'h4000, `TES_TC_ALERT, 0);
    sc(`TES_CMD_WRITE_TMK, 0, 5'h00, 0, 16'h0000, 0, 16'h8000, -1, 0);
    sc(`TES_CMD_WRITE_TMK_RETRY, 0, 5'h00, 0, 16'h0000, 0, 16'h8000, -1, 0);
    sc(`TES_CMD_OTHER, 0, 5'h04, 0, 16'h0000, 0, 16'h0000, `TES_TC_RECOV, 0);
    sc(`TES_CMD_OTHER, 0, 5'h0C, 0, 16'h0000, 0, 16'h0000, `TES_TC_FATAL, 0);
    ring_absent_pin_i <= 1'b1;
    sc(`TES_CMD_WRITE, 0, 5'h00, 0, 16'h0000, 0, 16'h0800, `TES_TC_REJECT, 0);
    ring_absent_pin_i <= 1'b0;
    sc(`TES_CMD_WRITE, 0, 5'h00, 0, 16'h0000, 6, 16'h0800, `TES_TC_UNRECOV, 1);
    chk("irq masked", 16'h0000, {15'h0, irq_o});
    wr(`TES_OFF_IRQ_MASK, 16'h0007);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("irq raised", 16'h0001, {15'h0, irq_o});
    rd(`TES_OFF_IRQ_STAT);
    chk("irq status", 16'h0003, d);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("irq cleared", 16'h0000, {15'h0, irq_o});
    wr(`TES_OFF_CMD_PTR, 16'h1234);
    #1 chk("cmd ptr", 16'h1234, cmd_ptr_o);
    rd(`TES_OFF_IRQ_STAT);
    chk("irq ptr bit", 16'h0004, d);
    rd(4'hF);
    chk("unmapped", 16'h0000, d);
    wr(`TES_OFF_RESIDUAL, 16'hFFFF);
    rd(`TES_OFF_RESIDUAL);
    chk("residual ro", 16'h0006, d);
    rd(`TES_OFF_CHAR);
    chk("characteristics", 16'h0001, d);
    rd(`TES_OFF_IRQ_MASK);
    chk("irq mask", 16'h0007, d);
    results;
  end
endmodule // tes_status_bank_tb_top
